// ---- shared/elac_defines.vh ----
`ifndef ELAC_DEFINES_VH
`define ELAC_DEFINES_VH
// Register word indices; the byte address on the bus is the index times four.
`define ELAC_IDX_STATUS     8'hE4
`define ELAC_IDX_OUTCTL     8'hE5
`define ELAC_IDX_LATCTL     8'hE9
`define ELAC_IDX_EVSTAT     8'hF0
`define ELAC_IDX_EVEN       8'hF1
`define ELAC_IDX_EVCLR      8'hF2
`define ELAC_ADDR_W         12
// Latch control register fields.
`define ELAC_LC_IR_POL      1
`define ELAC_LC_IR_IEN      2
`define ELAC_LC_IR_CLR      3
`define ELAC_LC_PW_POL      4
`define ELAC_LC_PW_IEN      5
`define ELAC_LC_PW_CLR      6
// Status register fields.
`define ELAC_ST_AFC_LSB     0
`define ELAC_ST_AFC_MSB     2
`define ELAC_ST_IR          3
`define ELAC_ST_VSYNC       4
// Output control register field.
`define ELAC_OC_SHIFT       2
// Event register fields.
`define ELAC_EV_IR          0
`define ELAC_EV_PW          1
`define ELAC_EV_W           2
// Reset values.
`define ELAC_RST_LATCTL     8'h00
`define ELAC_RST_OUTCTL     8'h04
`define ELAC_RST_EV         2'h0
`define ELAC_RST_SHIFT      1'b1
`endif

// ---- hdl/elac_edge_latch.v ----
`timescale 1ns/1ps
`include "elac_defines.vh"

// Synchroniser, edge detector and set-dominant latch for one input pin.
module elac_edge_latch
(
	input  wire clk_i,
	input  wire arst_n_i,
	input  wire pin_i,
	input  wire rise_sel_i,
	input  wire clear_i,
	output wire latch_o,
	output wire edge_o
);
	reg sync1_q;
	reg sync2_q;
	reg prev_q;
	reg latch_q;
	wire hit;

	// Edge seen on the synchronised level, selected by polarity.
	assign hit    = rise_sel_i ? (sync2_q & ~prev_q) : (~sync2_q & prev_q); // [RULE_01] [RULE_06]
	assign edge_o = hit;
	assign latch_o = latch_q;

	// Two flops first; only the second is ever looked at.
	always @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q  <= 1'b0;
			latch_q <= 1'b0;
		end
		else
		begin
			sync1_q <= pin_i; // [RULE_13]
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
			// A set in the same cycle as a clear wins, so no edge is lost.
			if (hit)
				latch_q <= 1'b1; // [RULE_13]
			else if (clear_i)
				latch_q <= 1'b0; // [RULE_02] [RULE_07]
		end
	end
endmodule

// ---- hdl/elac_top.v ----
// Function
// [RULE_01] IR latch sets on rising edge when polarity bit one, else falling.
// [RULE_02] Writing one to IR clear bit resets IR latch; write each time.
// [RULE_03] IR enable high: IR request low-active equals inverse of IR latch.
// [RULE_04] IR enable low: IR request held high.
// [RULE_05] Status bit 3 reads IR latch state.
// [RULE_06] Power latch sets on rising edge when polarity one, else falling.
// [RULE_07] Writing one to power clear bit resets power latch; write each time.
// [RULE_08] Power enable high: power request equals inverse of power latch.
// [RULE_09] Power enable low: power request held high.
// [RULE_10] Status bits 2..0 report AFC comparator code, tracked continuously.
// [RULE_11] Output control bit 2 selects lowered thresholds at zero, standard at one.
// [RULE_12] Status VSYNC bit reads inverse of vertical sync pin.
// [RULE_13] Pins synchronised before edge detection; set wins over clear.
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`include "elac_defines.vh"

module elac_top
(
	input  wire        CLK_SYS_I,
	input  wire        ARST_N_I,
	input  wire        PSEL_I,
	input  wire        PENABLE_I,
	input  wire        PWRITE_I,
	input  wire [11:0] PADDR_I,
	input  wire [31:0] PWDATA_I,
	output reg  [31:0] PRDATA_O,
	output reg         PREADY_O,
	output reg         PSLVERR_O,
	input  wire        INFRARED_INPUT_PIN_I,
	input  wire        POWER_INPUT_PIN_I,
	input  wire        VSYNC_PIN_I,
	input  wire [2:0]  AFC_LEVEL_CODE_I,
	output reg         AFC_RANGE_SHIFT_O,
	output reg         IR_IRQ_N_O,
	output reg         POWER_IRQ_N_O,
	output reg         IRQ_O
);
	// ****************************************************************
	// Registers and wires
	// ****************************************************************
	reg  [7:0]            latctl_q;
	reg  [`ELAC_EV_W-1:0] ev_stat_q;
	reg  [`ELAC_EV_W-1:0] ev_en_q;
	reg                   ir_clr_q;
	reg                   pw_clr_q;
	reg  [7:0]            status_d;
	reg  [31:0]           rdata_d;
	reg                   err_d;
	wire                  ir_latch;
	wire                  pw_latch;
	wire                  ir_edge;
	wire                  pw_edge;
	wire [`ELAC_EV_W-1:0] ev_hit;
	wire                  setup;
	wire                  wr_acc;
	wire [`ELAC_EV_W-1:0] ev_clr;

	// ****************************************************************
	// Latches
	// ****************************************************************

	// One instance per latch pin; clear pulses come from the bus write decode.
	elac_edge_latch u_ir
	(
		.clk_i      (CLK_SYS_I),
		.arst_n_i   (ARST_N_I),
		.pin_i      (INFRARED_INPUT_PIN_I),
		.rise_sel_i (latctl_q[`ELAC_LC_IR_POL]),
		.clear_i    (ir_clr_q),
		.latch_o    (ir_latch),
		.edge_o     (ir_edge)
	);

	elac_edge_latch u_pw
	(
		.clk_i      (CLK_SYS_I),
		.arst_n_i   (ARST_N_I),
		.pin_i      (POWER_INPUT_PIN_I),
		.rise_sel_i (latctl_q[`ELAC_LC_PW_POL]),
		.clear_i    (pw_clr_q),
		.latch_o    (pw_latch),
		.edge_o     (pw_edge)
	);

	// ****************************************************************
	// Bus decode
	// ****************************************************************

	// Every access completes in its first access cycle; PREADY is registered.
	assign setup  = PSEL_I & ~PENABLE_I;
	assign wr_acc = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I;
	assign ev_hit = {pw_edge, ir_edge};
	assign ev_clr = (wr_acc && PADDR_I == {`ELAC_IDX_EVCLR, 2'b00}) ?
	                PWDATA_I[`ELAC_EV_W-1:0] : {`ELAC_EV_W{1'b0}};

	// Status byte: AFC code, IR latch and inverted VSYNC, upper bits zero.
	always @*
	begin
		status_d = 8'h00;
		status_d[`ELAC_ST_AFC_MSB:`ELAC_ST_AFC_LSB] = AFC_LEVEL_CODE_I; // [RULE_10]
		status_d[`ELAC_ST_IR]    = ir_latch;     // [RULE_05]
		status_d[`ELAC_ST_VSYNC] = ~VSYNC_PIN_I; // [RULE_12]
	end

	// Read mux; unmapped addresses answer zero with an error.
	always @*
	begin
		rdata_d = 32'h0000_0000;
		err_d   = 1'b0;
		case (PADDR_I)
			{`ELAC_IDX_STATUS, 2'b00}: rdata_d[7:0] = status_d;
			{`ELAC_IDX_OUTCTL, 2'b00}: rdata_d[`ELAC_OC_SHIFT] = AFC_RANGE_SHIFT_O;
			{`ELAC_IDX_LATCTL, 2'b00}: rdata_d[7:0] = latctl_q;
			{`ELAC_IDX_EVSTAT, 2'b00}: rdata_d[`ELAC_EV_W-1:0] = ev_stat_q;
			{`ELAC_IDX_EVEN, 2'b00}:   rdata_d[`ELAC_EV_W-1:0] = ev_en_q;
			{`ELAC_IDX_EVCLR, 2'b00}:  rdata_d = 32'h0000_0000;
			default:                   err_d = 1'b1;
		endcase
	end

	// ****************************************************************
	// Register file
	// ****************************************************************

	// Clear bits are set-only: they make one-cycle pulses and read back zero.
	always @(posedge CLK_SYS_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			PREADY_O          <= 1'b0;
			PRDATA_O          <= 32'h0000_0000;
			PSLVERR_O         <= 1'b0;
			latctl_q          <= `ELAC_RST_LATCTL;
			AFC_RANGE_SHIFT_O <= `ELAC_RST_SHIFT;
			ev_en_q           <= `ELAC_RST_EV;
			ir_clr_q          <= 1'b0;
			pw_clr_q          <= 1'b0;
		end
		else
		begin
			PREADY_O  <= setup;
			PRDATA_O  <= setup && !PWRITE_I ? rdata_d : 32'h0000_0000;
			PSLVERR_O <= setup & err_d;
			ir_clr_q  <= 1'b0;
			pw_clr_q  <= 1'b0;
			if (wr_acc)
			begin
				case (PADDR_I)
					{`ELAC_IDX_LATCTL, 2'b00}:
					begin
						latctl_q <= PWDATA_I[7:0] &
						            ~((8'h01 << `ELAC_LC_IR_CLR) | (8'h01 << `ELAC_LC_PW_CLR));
						ir_clr_q <= PWDATA_I[`ELAC_LC_IR_CLR]; // [RULE_02]
						pw_clr_q <= PWDATA_I[`ELAC_LC_PW_CLR]; // [RULE_07]
					end
					{`ELAC_IDX_OUTCTL, 2'b00}:
						AFC_RANGE_SHIFT_O <= PWDATA_I[`ELAC_OC_SHIFT]; // [RULE_11]
					{`ELAC_IDX_EVEN, 2'b00}:
						ev_en_q <= PWDATA_I[`ELAC_EV_W-1:0];
					default:
						ev_en_q <= ev_en_q;
				endcase
			end
		end
	end

	// ****************************************************************
	// Events and interrupts
	// ****************************************************************

	// Sticky edge events; a new edge beats a clear in the same cycle.
	always @(posedge CLK_SYS_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
			ev_stat_q <= `ELAC_RST_EV;
		else
			ev_stat_q <= (ev_stat_q & ~ev_clr) | ev_hit;
	end

	// Request lines registered; the IR and power requests lag their latch by one cycle, IRQ_O lags the event status.
	always @(posedge CLK_SYS_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			IR_IRQ_N_O    <= 1'b1;
			POWER_IRQ_N_O <= 1'b1;
			IRQ_O         <= 1'b0;
		end
		else
		begin
			IR_IRQ_N_O    <= latctl_q[`ELAC_LC_IR_IEN] ? ~ir_latch : 1'b1; // [RULE_03] [RULE_04]
			POWER_IRQ_N_O <= latctl_q[`ELAC_LC_PW_IEN] ? ~pw_latch : 1'b1; // [RULE_08] [RULE_09]
			IRQ_O         <= |(ev_stat_q & ev_en_q);
		end
	end
endmodule

// ---- tb/elac_chk_sva.sv ----
`timescale 1ns/1ps
// Port-side checker; it keeps shadows of control words as written over the bus.
module elac_chk(input CLK_SYS_I,ARST_N_I,PSEL_I,PENABLE_I,PWRITE_I,PREADY_O,PSLVERR_O,
	IR_IRQ_N_O,POWER_IRQ_N_O,IRQ_O,AFC_RANGE_SHIFT_O,INFRARED_INPUT_PIN_I,POWER_INPUT_PIN_I,
	input [11:0] PADDR_I,input [31:0] PWDATA_I);
reg  [7:0] lc_q;
reg  [1:0] ev_q;
wire       wr = PSEL_I&PENABLE_I&PREADY_O&PWRITE_I;
// Shadows are taken at the write edge, as the slave takes them.
always @(posedge CLK_SYS_I or negedge ARST_N_I)
	if(!ARST_N_I) begin lc_q<=0; ev_q<=0; end
	else if(wr) begin
		if(PADDR_I==12'h3A4) lc_q<=PWDATA_I[7:0];
		if(PADDR_I==12'h3C4) ev_q<=PWDATA_I[1:0];
	end
default clocking @(posedge CLK_SYS_I); endclocking
default disable iff(!ARST_N_I);
property p_ir_off; (!lc_q[2])[*2] |-> IR_IRQ_N_O; endproperty
a_ir_off: assert property(p_ir_off) else $error("ir request low while off");
property p_pw_off; (!lc_q[5])[*2] |-> POWER_IRQ_N_O; endproperty
a_pw_off: assert property(p_pw_off) else $error("power request low while off");
property p_ir_set; lc_q[2]&&lc_q[1]&&$rose(INFRARED_INPUT_PIN_I) |-> ##[2:5] !IR_IRQ_N_O;
endproperty
a_ir_set: assert property(p_ir_set) else $error("ir rise missed");
property p_pw_set; lc_q[5]&&!lc_q[4]&&$fell(POWER_INPUT_PIN_I) |-> ##[2:5] !POWER_IRQ_N_O;
endproperty
a_pw_set: assert property(p_pw_set) else $error("power fall missed");
property p_ir_clr; wr&&PADDR_I==12'h3A4&&PWDATA_I[3]&&PWDATA_I[2] |-> ##[2:4] IR_IRQ_N_O;
endproperty
a_ir_clr: assert property(p_ir_clr) else $error("ir clear failed");
property p_oc; wr&&PADDR_I==12'h394 |=> AFC_RANGE_SHIFT_O==$past(PWDATA_I[2]); endproperty
a_oc: assert property(p_oc) else $error("range shift wrong");
property p_irq; (ev_q==0)[*2] |-> !IRQ_O; endproperty
a_irq: assert property(p_irq) else $error("irq while masked");
property p_rdy; PSEL_I&&!PENABLE_I |=> PREADY_O; endproperty
a_rdy: assert property(p_rdy) else $error("ready late");
property p_err; PSLVERR_O |-> PREADY_O; endproperty
a_err: assert property(p_err) else $error("error without ready");
endmodule
bind elac_top elac_chk u_chk(.*);

// ---- tb/elac_pin_model.sv ----
`timescale 1ns/1ps
// Drives the two latch pins, the sync pin and the comparator code.
module elac_pin_model(input wire clk_i,output reg ir_o,pw_o,vs_o,output reg [2:0] afc_o);
initial {ir_o,pw_o,vs_o,afc_o}=0;
// Each level is held well past the synchroniser so one edge is one event.
task drive(input p,v);
	@(posedge clk_i); if(p) pw_o<=v; else ir_o<=v;
	repeat(8) @(posedge clk_i);
	@(negedge clk_i);
endtask
// The comparator never yields a code above five.
task wiggle; @(posedge clk_i); vs_o<=$urandom; afc_o<=$urandom%6; endtask
endmodule

// ---- tb/test_edge_latches_and_afc_status.sv ----
`timescale 1ns/1ps
module test_edge_latches_and_afc_status;
reg clk=0,rst_n=0,sel=0,en=0,wr=0,err; reg [11:0] a=0; reg [31:0] wd=0,rd;
wire [31:0] prd; wire rdy,slv,ir,pw,vs,sh,irn,pwn,irq; wire [2:0] afc;
integer mismatches=0,checked=0,cyc=0,i,v,e,p,k,c;
elac_top DUT(.CLK_SYS_I(clk),.ARST_N_I(rst_n),.PSEL_I(sel),.PENABLE_I(en),.PWRITE_I(wr),
	.PADDR_I(a),.PWDATA_I(wd),.PRDATA_O(prd),.PREADY_O(rdy),.PSLVERR_O(slv),
	.INFRARED_INPUT_PIN_I(ir),.POWER_INPUT_PIN_I(pw),.VSYNC_PIN_I(vs),.AFC_LEVEL_CODE_I(afc),
	.AFC_RANGE_SHIFT_O(sh),.IR_IRQ_N_O(irn),.POWER_IRQ_N_O(pwn),.IRQ_O(irq));
elac_pin_model pm(.clk_i(clk),.ir_o(ir),.pw_o(pw),.vs_o(vs),.afc_o(afc));
initial forever #2.5 clk=~clk;
task wrap_up;
	if(mismatches==0&&checked>0) $display("Testbench passed");
	else $display("Testbench failed");
	$finish;
endtask
// A hang counts as a mismatch.
always @(posedge clk) if(++cyc==5000) begin mismatches++; wrap_up; end
task chk(input string n,input [31:0] s,x);
	checked++;
	if(s!==x) begin mismatches++; $display("ERROR %s exp %h got %h",n,x,s); end
endtask
// Ready is sampled at the rising edge; data is taken and the request dropped at that edge.
task xfer(input w,input [11:0] ad,input [31:0] d);
	@(posedge clk); sel<=1; wr<=w; a<=ad; wd<=d;
	@(posedge clk); en<=1;
	do @(posedge clk); while(rdy!==1);
	rd=prd; err=slv;
	sel<=0; en<=0;
endtask
initial begin
	v=$urandom(32'h3378);
	repeat(4) @(posedge clk); rst_n<=1;
	xfer(0,12'h3A4,0); chk("latch ctl",rd,0);
	xfer(0,12'h3FC,0); chk("unmapped",{rd[30:0],err},1);
	repeat(4) begin
		v=$urandom; xfer(1,12'h394,v); xfer(0,12'h394,0);
		chk("out ctl",rd,v&4); chk("shift",sh,v[2]);
	end
	repeat(6) begin
		pm.wiggle; xfer(0,12'h390,0); chk("status",rd,{!vs,1'b0,afc});
	end
	// Bit 1 of i picks the power pin, bit 0 the rising polarity.
	for(i=0;i<4;i++) begin
		e=i[1]?32'h20:4; p=i[1]?32'h10:2; k=i[1]?32'h40:8; c=e|(i[0]?p:0);
		pm.drive(i[1],i[0]); xfer(1,12'h3A4,c|k);
		for(v=0;v<2;v++) begin
			pm.drive(i[1],!i[0]^v); repeat(2) @(negedge clk);
			chk("req n",i[1]?pwn:irn,!v);
			if(!i[1]) begin xfer(0,12'h390,0); chk("ir latch",rd[3],v); end
		end
		xfer(1,12'h3A4,c&~e); repeat(2) @(negedge clk);
		chk("req off",i[1]?pwn:irn,1);
	end
	xfer(1,12'h3C8,3); xfer(1,12'h3C4,3); pm.drive(0,0);
	chk("irq",irq,1); xfer(0,12'h3C0,0); chk("event",rd,1);
	xfer(1,12'h3C4,0); repeat(2) @(negedge clk); chk("irq masked",irq,0);
	xfer(1,12'h3C8,3); xfer(0,12'h3C0,0); chk("event clr",rd,0);
	wrap_up;
end
endmodule
